/* hw/link_flags_pkg.sv */
// constants shared by the link status and error flag bank
package link_flags_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h09;
  localparam logic [7:0] ERROR_OFS   = 8'h0A;

  // ----------------------------------------------------------------
  // control register strobe positions
  // ----------------------------------------------------------------
  localparam int CTRL_ERR_CLR  = 2;
  localparam int CTRL_IRQ_CLR  = 3;
  localparam int CTRL_DATA_ACK = 4;
  localparam int CTRL_STOP     = 7;

  // ----------------------------------------------------------------
  // status register field positions
  // ----------------------------------------------------------------
  localparam int ST_DONE   = 0;
  localparam int ST_WAKEUP = 1;
  localparam int ST_ERROR  = 2;
  localparam int ST_IRQ    = 3;
  localparam int ST_IDENT  = 4;

  // ----------------------------------------------------------------
  // error register field positions
  // ----------------------------------------------------------------
  localparam int ER_READBACK = 0;
  localparam int ER_CHECKSUM = 1;
  localparam int ER_TIMEOUT  = 2;
  localparam int ER_PARITY   = 3;
  localparam int ER_SYNC     = 4;
  localparam int ER_WIDTH    = 5;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int MAX_FRAME_BITS    = 176;

endpackage : link_flags_pkg

/* hw/frame_len_timer.sv */
// bit-time counter that flags a frame reaching its longest length, on its MAX_BITS-th bit time
`timescale 1ns/1ps
`default_nettype none

module frame_len_timer #(
  parameter int MAX_BITS = link_flags_pkg::MAX_FRAME_BITS
) (
  input  wire logic ref_clk,   // system clock
  input  wire logic arst_n,    // async reset, active low
  input  wire logic start,     // frame begins
  input  wire logic finish,    // frame ends
  input  wire logic tick,      // one pulse per bit time
  output logic      overrun    // one-cycle pulse on overrun
);

  localparam int CW = $clog2(MAX_BITS + 1);
  localparam logic [CW-1:0] LAST = CW'(MAX_BITS - 1);

  logic          run_r;
  logic [CW-1:0] cnt_r;
  wire           hit = run_r && tick && (cnt_r == LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r   <= 1'b0;
      cnt_r   <= '0;
      overrun <= 1'b0;
    end else begin
      overrun <= hit;
      if (start) begin
        run_r <= 1'b1;
        cnt_r <= '0;
      end else if (finish || hit) begin
        run_r <= 1'b0;
      end else if (run_r && tick) begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

endmodule // frame_len_timer

`default_nettype wire

/* hw/link_status_flags.sv */
// status and error flag bank of the serial link controller
`timescale 1ns/1ps
`default_nettype none

module link_status_flags #(
  parameter int MAX_FRAME_BITS = link_flags_pkg::MAX_FRAME_BITS
) (
  input  wire logic       ref_clk,             // system clock, 200 MHz
  input  wire logic       arst_n,              // async reset, active low
  input  wire logic [7:0] addr,                // register address
  input  wire logic [7:0] wr_data,             // write data
  input  wire logic       wr_en,               // write strobe
  input  wire logic       rd_en,               // read strobe
  output logic      [7:0] rd_data,             // read data, cycle after rd_en
  input  wire logic       slave_mode,          // 1 slave, 0 master
  input  wire logic       ident_rx_evt,        // identifier taken from bus
  input  wire logic       frame_start_evt,     // transmission starts
  input  wire logic       frame_done_evt,      // transmission finished
  input  wire logic       bit_tick,            // one pulse per bit time
  input  wire logic       wakeup_tx_active,    // wakeup being sent
  input  wire logic       wakeup_rx_evt,       // wakeup received
  input  wire logic       sync_tol_evt,        // sync edges out of tolerance
  input  wire logic       parity_fail_evt,     // identifier parity bad
  input  wire logic       resp_missing_evt,    // slave did not answer
  input  wire logic       data_missing_evt,    // expected data absent
  input  wire logic       first_byte_done_evt, // first byte after id received
  input  wire logic       checksum_fail_evt,   // checksum mismatch
  input  wire logic       tx_active,           // device driving the bus
  input  wire logic       tx_level,            // level being driven
  input  wire logic       rx_pin,              // bus level, asynchronous
  output logic            irq_pending,         // interrupt pending level
  output logic            error_present,       // status error bit
  output logic            data_ack_pulse,      // data acknowledge strobe
  output logic            stop_pulse           // stop strobe
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire sel_ctrl   = (addr == link_flags_pkg::CTRL_OFS);
  wire sel_status = (addr == link_flags_pkg::STATUS_OFS);
  wire sel_error  = (addr == link_flags_pkg::ERROR_OFS);
  wire ctrl_wr    = wr_en && sel_ctrl;

  wire err_clr  = ctrl_wr && wr_data[link_flags_pkg::CTRL_ERR_CLR];
  wire irq_clr  = ctrl_wr && wr_data[link_flags_pkg::CTRL_IRQ_CLR];
  wire ack_wr   = ctrl_wr && wr_data[link_flags_pkg::CTRL_DATA_ACK];
  wire stop_wr  = ctrl_wr && wr_data[link_flags_pkg::CTRL_STOP];

  // ----------------------------------------------------------------
  // bus readback synchroniser and alignment
  // ----------------------------------------------------------------
  logic rx_meta_r;
  logic rx_sync_r;
  logic txa_d1_r;
  logic txa_d2_r;
  logic txl_d1_r;
  logic txl_d2_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // driven level delayed to match the two-stage synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txa_d1_r <= 1'b0;
      txa_d2_r <= 1'b0;
      txl_d1_r <= 1'b1;
      txl_d2_r <= 1'b1;
    end else begin
      txa_d1_r <= tx_active;
      txa_d2_r <= txa_d1_r;
      txl_d1_r <= tx_level;
      txl_d2_r <= txl_d1_r;
    end
  end

  wire readback_bad = bit_tick && txa_d2_r && (rx_sync_r != txl_d2_r);

  // ----------------------------------------------------------------
  // frame length supervision
  // ----------------------------------------------------------------
  wire frame_overrun;

  frame_len_timer #(
    .MAX_BITS (MAX_FRAME_BITS)
  ) u_frame_timer (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .start    (frame_start_evt),
    .finish   (frame_done_evt),
    .tick     (bit_tick),
    .overrun  (frame_overrun)
  );

  // ----------------------------------------------------------------
  // acknowledge window after the identifier
  // ----------------------------------------------------------------
  logic ack_wait_r;
  logic ack_wait_nxt;

  wire ack_late = ack_wait_r && first_byte_done_evt && !(ack_wr || stop_wr);

  always_comb begin
    ack_wait_nxt = ack_wait_r;
    if (ident_rx_evt && slave_mode) begin
      ack_wait_nxt = 1'b1;
    end
    if (ack_wr || stop_wr || first_byte_done_evt || frame_start_evt) begin
      ack_wait_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_wait_r <= 1'b0;
    end else begin
      ack_wait_r <= ack_wait_nxt;
    end
  end

  // ----------------------------------------------------------------
  // error register
  // ----------------------------------------------------------------
  logic [link_flags_pkg::ER_WIDTH-1:0] err_r;
  logic [link_flags_pkg::ER_WIDTH-1:0] err_set;
  logic [link_flags_pkg::ER_WIDTH-1:0] err_nxt;

  wire timeout_hit = (resp_missing_evt && !slave_mode)
                   || (data_missing_evt && slave_mode)
                   || frame_overrun
                   || ack_late;

  always_comb begin
    err_set = '0;
    err_set[link_flags_pkg::ER_SYNC]     = sync_tol_evt && slave_mode;
    err_set[link_flags_pkg::ER_PARITY]   = parity_fail_evt && slave_mode;
    err_set[link_flags_pkg::ER_TIMEOUT]  = timeout_hit;
    err_set[link_flags_pkg::ER_CHECKSUM] = checksum_fail_evt;
    err_set[link_flags_pkg::ER_READBACK] = readback_bad;
  end

  // a new error in the clearing cycle survives the clear
  always_comb begin
    err_nxt = err_r;
    if (err_clr) begin
      err_nxt = '0;
    end
    err_nxt = err_nxt | err_set;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_r <= '0;
    end else begin
      err_r <= err_nxt;
    end
  end

  wire any_err_set = |err_set;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic ident_r;
  logic ident_nxt;
  logic irq_nxt;
  logic error_nxt;
  logic wake_rx_r;
  logic wake_rx_nxt;
  logic done_r;
  logic done_nxt;

  wire irq_set = ident_rx_evt || frame_done_evt || wakeup_rx_evt || any_err_set;

  always_comb begin
    ident_nxt = ident_r;
    if (ack_wr || stop_wr || frame_start_evt) begin
      ident_nxt = 1'b0;
    end
    if (ident_rx_evt) begin
      ident_nxt = 1'b1;
    end
  end

  always_comb begin
    irq_nxt = irq_pending;
    if (irq_clr) begin
      irq_nxt = 1'b0;
    end
    if (irq_set) begin
      irq_nxt = 1'b1;
    end
  end

  always_comb begin
    error_nxt = error_present;
    if (err_clr) begin
      error_nxt = 1'b0;
    end
    if (any_err_set) begin
      error_nxt = 1'b1;
    end
  end

  always_comb begin
    wake_rx_nxt = wake_rx_r;
    if (frame_start_evt) begin
      wake_rx_nxt = 1'b0;
    end
    if (wakeup_rx_evt) begin
      wake_rx_nxt = 1'b1;
    end
  end

  always_comb begin
    done_nxt = done_r;
    if (frame_start_evt) begin
      done_nxt = 1'b0;
    end
    if (frame_done_evt) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ident_r       <= 1'b0;
      irq_pending   <= 1'b0;
      error_present <= 1'b0;
      wake_rx_r     <= 1'b0;
      done_r        <= 1'b0;
    end else begin
      ident_r       <= ident_nxt;
      irq_pending   <= irq_nxt;
      error_present <= error_nxt;
      wake_rx_r     <= wake_rx_nxt;
      done_r        <= done_nxt;
    end
  end

  logic [7:0] status_word;

  always_comb begin
    status_word = link_flags_pkg::REG_RESET;
    status_word[link_flags_pkg::ST_IDENT]  = ident_r;
    status_word[link_flags_pkg::ST_IRQ]    = irq_pending;
    status_word[link_flags_pkg::ST_ERROR]  = error_present;
    status_word[link_flags_pkg::ST_WAKEUP] = wakeup_tx_active || wake_rx_r;
    status_word[link_flags_pkg::ST_DONE]   = done_r;
  end

  // ----------------------------------------------------------------
  // read path and control strobes
  // ----------------------------------------------------------------
  wire [7:0] error_word = {3'h0, err_r};

  wire [7:0] rd_mux = !rd_en      ? link_flags_pkg::READ_ZERO :
                      sel_status ? status_word :
                      sel_error  ? error_word  :
                      link_flags_pkg::READ_ZERO;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data        <= link_flags_pkg::REG_RESET;
      data_ack_pulse <= 1'b0;
      stop_pulse     <= 1'b0;
    end else begin
      rd_data        <= rd_mux;
      data_ack_pulse <= ack_wr;
      stop_pulse     <= stop_wr;
    end
  end

endmodule // link_status_flags

`default_nettype wire

/* sim/link_status_flags_sva.sv */
// port assertions for the link status and error flag bank
`timescale 1ns/1ps
`default_nettype none
module link_status_flags_chk (
  input wire logic       ref_clk,           // clock
  input wire logic       arst_n,            // reset, active low
  input wire logic [7:0] addr,              // address
  input wire logic [7:0] wr_data,           // write data
  input wire logic       wr_en,             // write strobe
  input wire logic       rd_en,             // read strobe
  input wire logic [7:0] rd_data,           // read data
  input wire logic       checksum_fail_evt, // checksum event
  input wire logic       irq_pending,       // irq level
  input wire logic       error_present,     // error level
  input wire logic       data_ack_pulse,    // ack strobe
  input wire logic       stop_pulse         // stop strobe
);
  wire ctl_wr = wr_en && addr == 8'h08;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_cks; checksum_fail_evt |=> error_present && irq_pending; endproperty
  a_cks: assert property (p_cks) else $error("checksum event not flagged");
  property p_rose; $rose(error_present) |-> irq_pending; endproperty
  a_rose: assert property (p_rose) else $error("error without irq");
  property p_irqh; irq_pending && !(ctl_wr && wr_data[3]) |=> irq_pending; endproperty
  a_irqh: assert property (p_irqh) else $error("irq dropped");
  property p_errh; error_present && !(ctl_wr && wr_data[2]) |=> error_present; endproperty
  a_errh: assert property (p_errh) else $error("error dropped");
  property p_ctl; rd_en && addr == 8'h08 |=> rd_data == 8'h00; endproperty
  a_ctl: assert property (p_ctl) else $error("control reads nonzero");
  property p_erd; rd_en && addr == 8'h0A |=> rd_data[7:5] == 3'h0; endproperty
  a_erd: assert property (p_erd) else $error("unused error bits set");
  property p_srd;
    rd_en && addr == 8'h09 |=> rd_data[3:2] == $past({irq_pending, error_present});
  endproperty
  a_srd: assert property (p_srd) else $error("status read mismatch");
  property p_ack;
    ctl_wr && wr_data[4] |=> data_ack_pulse ##1 (!data_ack_pulse || $past(ctl_wr && wr_data[4]));
  endproperty
  a_ack: assert property (p_ack) else $error("ack strobe wrong");
  property p_acks; data_ack_pulse |-> $past(ctl_wr && wr_data[4]); endproperty
  a_acks: assert property (p_acks) else $error("ack strobe unasked");
  property p_stop;
    ctl_wr && wr_data[7] |=> stop_pulse ##1 (!stop_pulse || $past(ctl_wr && wr_data[7]));
  endproperty
  a_stop: assert property (p_stop) else $error("stop strobe wrong");
endmodule // link_status_flags_chk
bind link_status_flags link_status_flags_chk i_link_status_flags_chk (
  .ref_clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .checksum_fail_evt,
  .irq_pending, .error_present, .data_ack_pulse, .stop_pulse);
`default_nettype wire

/* sim/link_bus_echo.sv */
// bus partner: echoes the driven level, inverted on demand
`timescale 1ns/1ps
`default_nettype none
module link_bus_echo (
  input  wire logic tx_active, // device drives bus
  input  wire logic tx_level,  // level driven
  input  wire logic flip,      // corrupt the echo
  output logic      rx_pin     // bus level seen
);
  // released bus idles recessive through the pull-up
  assign rx_pin = tx_active ? (tx_level ^ flip) : 1'b1;
endmodule // link_bus_echo
`default_nettype wire

/* sim/link_status_flags_tb.sv */
// self-checking bench for the link status and error flag bank
`timescale 1ns/1ps
`default_nettype none
module link_status_flags_tb;
  logic       ref_clk, arst_n, wr_en, rd_en, slave_mode, tick;
  logic       wk_tx, tx_act, tx_lvl, flip, rx_pin, irq_p, err_p, ack_p, stop_p;
  logic [7:0] addr, wr_data, rd_data;
  logic [9:0] ev;
  int         num_errors, check_count;
  localparam logic [9:0] EM [9] = '{10'h010, 10'h020, 10'h040, 10'h080, 10'h200,
                                    10'h010, 10'h020, 10'h080, 10'h040};
  localparam logic       SL [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam logic [7:0] EX [9] = '{8'h10, 8'h08, 8'h04, 8'h04, 8'h02,
                                    8'h00, 8'h00, 8'h00, 8'h00};

  link_status_flags #(.MAX_FRAME_BITS(8)) i_link_status_flags (
    .ref_clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .slave_mode,
    .ident_rx_evt(ev[0]), .frame_start_evt(ev[1]), .frame_done_evt(ev[2]),
    .bit_tick(tick), .wakeup_tx_active(wk_tx), .wakeup_rx_evt(ev[3]),
    .sync_tol_evt(ev[4]), .parity_fail_evt(ev[5]), .resp_missing_evt(ev[6]),
    .data_missing_evt(ev[7]), .first_byte_done_evt(ev[8]), .checksum_fail_evt(ev[9]),
    .tx_active(tx_act), .tx_level(tx_lvl), .rx_pin, .irq_pending(irq_p),
    .error_present(err_p), .data_ack_pulse(ack_p), .stop_pulse(stop_p));
  link_bus_echo i_link_bus_echo (.tx_active(tx_act), .tx_level(tx_lvl), .flip, .rx_pin);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(n, rd_data, e);
  endtask
  task automatic fire(input logic [9:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= '0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t_regs;
    rd(8'h09, 8'h00, "status");
    rd(8'h0A, 8'h00, "error");
    wr(8'h0A, 8'hFF);
    wr(8'h09, 8'hFF);
    wr(8'h08, 8'h0C);
    rd(8'h0A, 8'h00, "error");
    rd(8'h09, 8'h00, "status");
    rd(8'h08, 8'h00, "control");
    rd(8'h3C, 8'h00, "unmapped");
    $display("t_regs done");
  endtask
  task automatic t_errs;
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      slave_mode <= SL[i];
      fire(EM[i]);
      rd(8'h0A, EX[i], "error");
      rd(8'h09, (EX[i] != 0) ? 8'h0C : 8'h00, "status");
      chk("irq and error", {6'h00, irq_p, err_p}, (EX[i] != 0) ? 8'h03 : 8'h00);
      wr(8'h08, 8'h00);
      rd(8'h0A, EX[i], "error");
      wr(8'h08, 8'h04);
      rd(8'h0A, 8'h00, "error");
      rd(8'h09, (EX[i] != 0) ? 8'h08 : 8'h00, "status");
      wr(8'h08, 8'h08);
      rd(8'h09, 8'h00, "status");
    end
    $display("t_errs done");
  endtask
  task automatic t_frame;
    fire(10'h004);
    rd(8'h09, 8'h09, "status");
    wr(8'h08, 8'h08);
    rd(8'h09, 8'h01, "status");
    fire(10'h002);
    rd(8'h09, 8'h00, "status");
    ticks(7);
    rd(8'h0A, 8'h00, "error");
    ticks(1);
    rd(8'h0A, 8'h04, "error");
    wr(8'h08, 8'h0C);
    fire(10'h006);
    rd(8'h09, 8'h09, "status");
    $display("t_frame done");
  endtask
  task automatic t_ident;
    @(posedge ref_clk);
    slave_mode <= 1'b1;
    wr(8'h08, 8'h0C);
    fire(10'h002);
    fire(10'h001);
    rd(8'h09, 8'h18, "status");
    wr(8'h08, 8'h10);
    #1 chk("ack strobe", {7'h00, ack_p}, 8'h01);
    fire(10'h100);
    rd(8'h09, 8'h08, "status");
    fire(10'h001);
    wr(8'h08, 8'h80);
    #1 chk("stop strobe", {7'h00, stop_p}, 8'h01);
    fire(10'h100);
    rd(8'h0A, 8'h00, "error");
    fire(10'h001);
    fire(10'h100);
    rd(8'h0A, 8'h04, "error");
    wr(8'h08, 8'h1C);
    @(posedge ref_clk);
    wk_tx <= 1'b1;
    rd(8'h09, 8'h02, "status");
    @(posedge ref_clk);
    wk_tx <= 1'b0;
    rd(8'h09, 8'h00, "status");
    fire(10'h008);
    rd(8'h09, 8'h0A, "status");
    fire(10'h002);
    rd(8'h09, 8'h08, "status");
    $display("t_ident done");
  endtask
  task automatic t_readback;
    fire(10'h004);
    wr(8'h08, 8'h0C);
    @(posedge ref_clk);
    tx_act <= 1'b1;
    ticks(2);
    tx_lvl <= 1'b1;
    ticks(2);
    rd(8'h0A, 8'h00, "error");
    @(posedge ref_clk);
    flip <= 1'b1;
    ticks(2);
    rd(8'h0A, 8'h01, "error");
    @(posedge ref_clk);
    tx_act <= 1'b0;
    flip   <= 1'b0;
    $display("t_readback done");
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    {arst_n, wr_en, rd_en, slave_mode, tick, wk_tx, tx_act, tx_lvl, flip} = '0;
    {addr, wr_data, ev} = '0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_errs();
    t_frame();
    t_ident();
    t_readback();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
endmodule // link_status_flags_tb
`default_nettype wire
